// File: include/usd_map.svh
// Purpose: offsets, field positions and timing counts of the status/endpoint/descriptor block
// Assumes: byte-wide register port, 16-bit data-space addresses
// Notes: included by the package and the design
`ifndef USD_MAP_SVH
`define USD_MAP_SVH

// register offsets
`define USD_OFF_STAT      16'h0e00
`define USD_OFF_CTRL      16'h0e01
`define USD_OFF_ADDR      16'h0e02
`define USD_OFF_FRML      16'h0e03
`define USD_OFF_FRMH      16'h0e04
`define USD_OFF_EP_BASE   16'h0e10
`define USD_OFF_EP_MASK   16'hfff8

// control register bits
`define USD_CTRL_DONE     0
`define USD_CTRL_SUSP     1
`define USD_CTRL_BRST     2

// endpoint pair control bits
`define USD_EP_STALL      0
`define USD_EP_INEN       1
`define USD_EP_OUTEN      2
`define USD_EP_CONDIS     3
`define USD_EP_HSHK       4

// descriptor status byte bits
`define USD_BD_OWN        7
`define USD_BD_PID_LO     2

// memory map
`define USD_DPL_BASE      16'h2000
`define USD_DPL_LAST      16'h21ef
`define USD_DPB_BASE      16'h0370
`define USD_DPB_LAST      16'h037f
`define USD_CPU_BASE      16'h2200
`define USD_CPU_LAST      16'h23ff
`define USD_DPB_IDX       10'h1f0
`define USD_CPU_IDX       10'h200
`define USD_MEM_BYTES     1024

// status fifo and timing
`define USD_FIFO_DEPTH    3'h4
`define USD_CLK_PS        4000
`define USD_TCY_PS        83333
`define USD_REARM_TCY     6
`define USD_REARM_CYC     ((`USD_REARM_TCY * `USD_TCY_PS) / `USD_CLK_PS)
`define USD_STAT_CYC      2

`endif

// File: include/usd_pkg.sv
// Purpose: types shared by the status/endpoint/descriptor block
// Assumes: constants come from usd_map.svh
// Notes: engine-side groups travel as packed structs
`include "usd_map.svh"
package usd_pkg;
  typedef enum logic [1:0] {
    USD_PID_OUT   = 2'b00,
    USD_PID_IN    = 2'b01,
    USD_PID_SETUP = 2'b10
  } usd_pid_t;

  typedef enum logic [1:0] {
    USD_HS_ACK    = 2'b00,
    USD_HS_NAK    = 2'b01,
    USD_HS_NONE   = 2'b10,
    USD_HS_IGNORE = 2'b11
  } usd_hs_t;

  typedef enum logic {
    USD_ARM_IDLE = 1'b0,
    USD_ARM_LOAD = 1'b1
  } usd_arm_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] ep;
    usd_pid_t   pid;
  } usd_tok_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] ep;
    logic       dir;
    logic       ppbi;
    logic [6:0] bd;
    logic [3:0] pid;
    logic [9:0] cnt;
  } usd_done_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] ep;
  } usd_stall_t;

  typedef struct packed {
    logic [3:0][7:0] fifo;
    logic [1:0]      wptr;
    logic [1:0]      rptr;
    logic [2:0]      count;
    logic [7:0]      stat;
    logic            done;
    usd_arm_t        arm;
    logic [7:0][7:0] ep;
    logic [7:0]      addr;
    logic [10:0]     frame;
    logic            susp;
    logic            brst;
    logic [7:0]      rdata;
  } usd_state_t;
endpackage

// File: verilog/usd_core.sv
// Summary of operation
// - each status entry holds endpoint number, direction and ping-pong pointer.
// - status window is loaded at least one cycle before the done flag rises.
// - status window reads the head of a four-entry byte-wide fifo.
// - each completed transfer posts an entry unless the fifo is full; later ones queue behind it.
// - clearing done pops the fifo; flag re-rises quickly when entries remain.
// - a permitted token arriving while the fifo is full is answered with NAK.
// - eight endpoint pairs, each with an identical control register.
// - handshake enable selects handshaking; firmware clears it only for isochronous.
// - setup accepted only with control disable clear and both directions enabled.
// - out enable permits OUT tokens, in enable permits IN tokens.
// - stalled flag set on every stall, held until firmware or reset clears it.
// - device address drives decode and clears on bus reset and device reset.
// - eleven-bit frame number reloaded on each SOF unless suspended, read-only to software.
// - frame number frozen, not reloaded by SOF, while suspended.
// - dual-port, banked, cpu-only and read-zero regions of the data space.
// - descriptor is status, count, address low, address high; status at base+4n-1.
// - descriptor writeback only once the endpoint in enable is set.
// - descriptor bytes are not reset.
// - owner bit set hands descriptor and buffer to the engine, clear to cpu.
// - owner bit and count bits nine and eight keep meaning in both modes.
// - suspend stops the engine clock and enters low power.
// - engine clears the owner bit when a transaction completes on an endpoint with in enable set.
// - byte count is ten bits, low byte in count, upper two in status.
// Purpose: status fifo, endpoint control, address, frame and descriptor ram
// Assumes: engine-side inputs are on ref_clk; one cpu access per cycle
// Notes: descriptor ram has no reset; access is not arbitrated, the owner bit is never checked
`timescale 1ns/100ps
`include "usd_map.svh"
module usd_core (
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire logic [15:0]         cpu_addr,
  input  wire logic [7:0]          cpu_wdata,
  input  wire logic                cpu_wr,
  input  wire logic                cpu_rd,
  output      logic [7:0]          cpu_rdata,
  input  wire usd_pkg::usd_tok_t   eng_tok,
  output      usd_pkg::usd_hs_t    eng_hs,
  input  wire usd_pkg::usd_done_t  eng_done,
  input  wire usd_pkg::usd_stall_t eng_stall,
  input  wire logic                eng_bus_reset,
  input  wire logic                eng_sof,
  input  wire logic [10:0]         eng_sof_frame,
  input  wire logic [8:0]          eng_rd_idx,
  output      logic [7:0]          eng_rd_data,
  output      logic [7:0]          dev_addr,
  output      logic                done_flag,
  output      logic                sie_clk_en,
  output      logic                low_power
);
  import usd_pkg::*;

  usd_state_t r_reg;
  usd_state_t r_next;
  logic [7:0] mem [`USD_MEM_BYTES];
  logic [7:0] eng_q_reg;

  logic       hit;
  logic [9:0] idx;
  logic       pop;
  logic       push;
  logic       full;
  logic       allowed;
  logic [7:0] tok_ep;
  logic       wb;
  logic [8:0] wb_idx;

  // cpu address decode onto the shared ram
  // region map
  always_comb
  begin
    hit = 1'b0;
    idx = 10'h000;
    if (cpu_addr >= `USD_DPL_BASE && cpu_addr <= `USD_DPL_LAST)
    begin
      hit = 1'b1;
      idx = 10'(cpu_addr - `USD_DPL_BASE);
    end
    else if (cpu_addr >= `USD_DPB_BASE && cpu_addr <= `USD_DPB_LAST)
    begin
      hit = 1'b1;
      idx = `USD_DPB_IDX + 10'(cpu_addr - `USD_DPB_BASE);
    end
    else if (cpu_addr >= `USD_CPU_BASE && cpu_addr <= `USD_CPU_LAST)
    begin
      hit = 1'b1;
      idx = `USD_CPU_IDX + 10'(cpu_addr - `USD_CPU_BASE);
    end
  end

  assign full = (r_reg.count == `USD_FIFO_DEPTH);
  assign tok_ep = r_reg.ep[eng_tok.ep];
  // descriptor live only with in enable
  assign wb = eng_done.valid && r_reg.ep[eng_done.ep][`USD_EP_INEN];
  assign wb_idx = {eng_done.bd, 2'b00} - 9'h001;

  // token answer
  always_comb
  begin
    unique case (eng_tok.pid)
      USD_PID_OUT:
        allowed = tok_ep[`USD_EP_OUTEN];
      USD_PID_IN:
        allowed = tok_ep[`USD_EP_INEN];
      USD_PID_SETUP:
        allowed = !tok_ep[`USD_EP_CONDIS] && tok_ep[`USD_EP_INEN] && tok_ep[`USD_EP_OUTEN];
      default:
        allowed = 1'b0;
    endcase
    if (!eng_tok.valid || !allowed)
      eng_hs = USD_HS_IGNORE;
    else if (full)
      eng_hs = USD_HS_NAK;
    else if (tok_ep[`USD_EP_HSHK])
      eng_hs = USD_HS_ACK;
    else
      eng_hs = USD_HS_NONE;
  end

  assign push = eng_done.valid && !full;
  assign pop  = cpu_wr && cpu_addr == `USD_OFF_CTRL && !cpu_wdata[`USD_CTRL_DONE] && r_reg.done;

  always_comb
  begin
    r_next = r_reg;
    r_next.rdata = 8'h00;
    if (push)
    begin
      r_next.fifo[r_reg.wptr] = {1'b0, 1'b0, eng_done.ep, eng_done.dir, eng_done.ppbi, 1'b0};
      r_next.wptr = r_reg.wptr + 2'h1;
    end
    if (pop)
    begin
      r_next.done = 1'b0;
      r_next.rptr = r_reg.rptr + 2'h1;
    end
    if (push && !pop)
      r_next.count = r_reg.count + 3'h1;
    else if (pop && !push)
      r_next.count = r_reg.count - 3'h1;
    unique case (r_reg.arm)
      USD_ARM_IDLE:
        if (!r_reg.done && r_reg.count != 3'h0)
        begin
          r_next.stat = r_reg.fifo[r_reg.rptr];
          r_next.arm  = USD_ARM_LOAD;
        end
      USD_ARM_LOAD:
      begin
        r_next.done = 1'b1;
        r_next.arm  = USD_ARM_IDLE;
      end
    endcase
    if (cpu_wr)
    begin
      if (cpu_addr == `USD_OFF_CTRL)
      begin
        r_next.susp = cpu_wdata[`USD_CTRL_SUSP];
        if (!cpu_wdata[`USD_CTRL_BRST])
          r_next.brst = 1'b0;
      end
      if (cpu_addr == `USD_OFF_ADDR)
        r_next.addr = cpu_wdata;
      if ((cpu_addr & `USD_OFF_EP_MASK) == `USD_OFF_EP_BASE)
        r_next.ep[cpu_addr[2:0]] = cpu_wdata;
    end
    // stall sets flag, set wins over clear
    if (eng_stall.valid)
      r_next.ep[eng_stall.ep][`USD_EP_STALL] = 1'b1;
    if (eng_bus_reset)
    begin
      r_next.addr = 8'h00;
      r_next.brst = 1'b1;
    end
    if (eng_sof && !r_reg.susp)
      r_next.frame = eng_sof_frame;
    if (cpu_rd)
    begin
      if (hit)
        r_next.rdata = mem[idx];
      else if (cpu_addr == `USD_OFF_STAT)
        r_next.rdata = r_reg.stat;
      else if (cpu_addr == `USD_OFF_CTRL)
        r_next.rdata = {5'h00, r_reg.brst, r_reg.susp, r_reg.done};
      else if (cpu_addr == `USD_OFF_ADDR)
        r_next.rdata = r_reg.addr;
      else if (cpu_addr == `USD_OFF_FRML)
        r_next.rdata = r_reg.frame[7:0];
      else if (cpu_addr == `USD_OFF_FRMH)
        r_next.rdata = {5'h00, r_reg.frame[10:8]};
      else if ((cpu_addr & `USD_OFF_EP_MASK) == `USD_OFF_EP_BASE)
        r_next.rdata = r_reg.ep[cpu_addr[2:0]];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  // shared ram, not reset
  // descriptor bytes undefined after reset
  always_ff @(posedge ref_clk)
  begin
    if (cpu_wr && hit)
      mem[idx] <= cpu_wdata;
    // ten-bit count split over two bytes
    // owner and count bits fixed meaning
    if (wb)
    begin
      mem[wb_idx] <= {1'b0, 1'b0, eng_done.pid, eng_done.cnt[9:8]};
      mem[wb_idx + 9'h001] <= eng_done.cnt[7:0];
    end
    eng_q_reg <= mem[{1'b0, eng_rd_idx}];
  end

  assign cpu_rdata   = r_reg.rdata;
  assign eng_rd_data = eng_q_reg;
  assign dev_addr    = r_reg.addr;
  assign done_flag   = r_reg.done;
  assign sie_clk_en  = !r_reg.susp;
  assign low_power   = r_reg.susp;

  sequence s_clear_more;
    pop && r_reg.count > 3'h1;
  endsequence

  sequence s_full_tok;
    eng_tok.valid && allowed && full;
  endsequence

  a_done_rearm: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_clear_more |-> ##[1:4] r_reg.done)
    else $error("done flag not re-raised after pop");

  a_full_nak: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_full_tok |-> eng_hs == USD_HS_NAK)
    else $error("full fifo token not nak");

  a_fifo_bound: assert property (@(posedge ref_clk) disable iff (!reset_n)
    r_reg.count <= `USD_FIFO_DEPTH)
    else $error("fifo count over depth");

  a_status_head: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(r_reg.done) |-> r_reg.stat == r_reg.fifo[r_reg.rptr])
    else $error("status not oldest entry");

  a_stall_sets: assert property (@(posedge ref_clk) disable iff (!reset_n)
    eng_stall.valid |=> r_reg.ep[$past(eng_stall.ep)][`USD_EP_STALL])
    else $error("stall flag not set");

  a_addr_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    eng_bus_reset |=> dev_addr == 8'h00)
    else $error("address not cleared by bus reset");

  a_frame_load: assert property (@(posedge ref_clk) disable iff (!reset_n)
    eng_sof && !low_power |=> r_reg.frame == $past(eng_sof_frame))
    else $error("frame not reloaded on sof");

  a_out_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    eng_tok.valid && eng_tok.pid == USD_PID_OUT && !tok_ep[`USD_EP_OUTEN]
      |-> eng_hs == USD_HS_IGNORE)
    else $error("out token accepted while disabled");

  a_flag_delay: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(r_reg.done) |-> $past(r_reg.arm) == USD_ARM_LOAD)
    else $error("done raised without status load");

  sequence s_first_done;
    eng_done.valid && r_reg.count == 3'h0 && !r_reg.done && r_reg.arm == USD_ARM_IDLE;
  endsequence

  // fields of a freshly posted entry
  a_status_fields: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_first_done |-> ##`USD_STAT_CYC r_reg.stat == {2'b00, $past(eng_done.ep, `USD_STAT_CYC),
      $past(eng_done.dir, `USD_STAT_CYC), $past(eng_done.ppbi, `USD_STAT_CYC), 1'b0})
    else $error("status fields wrong");

  a_pop_order: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_clear_more |-> ##`USD_STAT_CYC
      r_reg.stat == $past(r_reg.fifo[r_reg.rptr + 2'h1], `USD_STAT_CYC))
    else $error("status not next oldest entry");

  a_push_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
    eng_done.valid && !full && !pop |=> r_reg.count == $past(r_reg.count) + 3'h1)
    else $error("completed transfer not queued");

  a_in_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    eng_tok.valid && eng_tok.pid == USD_PID_IN && !tok_ep[`USD_EP_INEN]
      |-> eng_hs == USD_HS_IGNORE)
    else $error("in token accepted while disabled");

  a_setup_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    eng_tok.valid && eng_tok.pid == USD_PID_SETUP && (tok_ep[`USD_EP_CONDIS]
      || !tok_ep[`USD_EP_INEN] || !tok_ep[`USD_EP_OUTEN]) |-> eng_hs == USD_HS_IGNORE)
    else $error("setup token accepted while gated");

  a_hshk_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
    eng_tok.valid && allowed && !full && !tok_ep[`USD_EP_HSHK] |-> eng_hs == USD_HS_NONE)
    else $error("handshake given while disabled");

  a_wb_owner: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wb |=> mem[$past(wb_idx)][`USD_BD_OWN] == 1'b0)
    else $error("owner bit not returned to cpu");

  a_wb_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wb |=> mem[$past(wb_idx) + 9'h001] == $past(eng_done.cnt[7:0]))
    else $error("count byte not written back");

  a_susp_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cpu_wr && cpu_addr == `USD_OFF_CTRL |=> low_power == $past(cpu_wdata[`USD_CTRL_SUSP]))
    else $error("suspend not taken from control write");
endmodule

// File: tb/usd_host_model.sv
// Purpose: engine-side stand-in raising tokens, done, stall, bus reset and sof
// Assumes: every change lands right after a rising edge of ref_clk
// Notes: idle fields show inverted values, never the last ones; the ram read index keeps its last value
`timescale 1ns/100ps
module usd_host_model (
  input  wire logic               ref_clk,
  input  wire usd_pkg::usd_hs_t   eng_hs,
  input  wire logic [7:0]         eng_rd_data,
  output usd_pkg::usd_tok_t       eng_tok,
  output usd_pkg::usd_done_t      eng_done,
  output usd_pkg::usd_stall_t     eng_stall,
  output logic                    eng_bus_reset,
  output logic                    eng_sof,
  output logic [10:0]             eng_sof_frame,
  output logic [8:0]              eng_rd_idx
);
  import usd_pkg::*;
  initial
  begin
    eng_tok = '0;
    eng_done = '0;
    eng_stall = '0;
    eng_bus_reset = 1'b0;
    eng_sof = 1'b0;
    eng_sof_frame = '0;
    eng_rd_idx = '0;
  end
  task automatic token(input logic [2:0] ep, input usd_pid_t pid, output usd_hs_t hs);
    @(posedge ref_clk);
    eng_tok <= usd_tok_t'{1'b1, ep, pid};
    @(posedge ref_clk);
    #1 hs = eng_hs;
    @(posedge ref_clk);
    eng_tok <= usd_tok_t'(~eng_tok);
  endtask
  task automatic done(input logic [2:0] ep, input logic dir, input logic ppbi,
                      input logic [6:0] bd, input logic [3:0] pid, input logic [9:0] cnt);
    @(posedge ref_clk);
    eng_done <= usd_done_t'{1'b1, ep, dir, ppbi, bd, pid, cnt};
  endtask
  task automatic done_end();
    @(posedge ref_clk);
    eng_done <= usd_done_t'(~eng_done);
  endtask
  task automatic stall(input logic [2:0] ep);
    @(posedge ref_clk);
    eng_stall <= usd_stall_t'{1'b1, ep};
    @(posedge ref_clk);
    eng_stall <= usd_stall_t'(~eng_stall);
  endtask
  task automatic bus_reset();
    @(posedge ref_clk);
    eng_bus_reset <= 1'b1;
    @(posedge ref_clk);
    eng_bus_reset <= 1'b0;
  endtask
  task automatic sof(input logic [10:0] f);
    @(posedge ref_clk);
    eng_sof <= 1'b1;
    eng_sof_frame <= f;
    @(posedge ref_clk);
    eng_sof <= 1'b0;
    eng_sof_frame <= ~f;
  endtask
  task automatic ram_rd(input logic [8:0] idx, output logic [7:0] d);
    @(posedge ref_clk);
    eng_rd_idx <= idx;
    @(posedge ref_clk);
    #1 d = eng_rd_data;
  endtask
endmodule

// File: tb/test_usb_sie_status_endpoint_bdt.sv
// Purpose: register-level checks of status fifo, endpoint control, frame and ram
// Assumes: byte register port, read data one cycle after the strobe
// Notes: engine events come from the host model
`timescale 1ns/100ps
`include "usd_map.svh"
module test_usb_sie_status_endpoint_bdt;
  import usd_pkg::*;
  logic        ref_clk;
  logic        reset_n;
  logic [15:0] cpu_addr;
  logic [7:0]  cpu_wdata;
  logic        cpu_wr;
  logic        cpu_rd;
  logic [7:0]  cpu_rdata;
  usd_tok_t    eng_tok;
  usd_hs_t     eng_hs;
  usd_hs_t     hs;
  usd_done_t   eng_done;
  usd_stall_t  eng_stall;
  logic        eng_bus_reset;
  logic        eng_sof;
  logic [10:0] eng_sof_frame;
  logic [8:0]  eng_rd_idx;
  logic [7:0]  eng_rd_data;
  logic [7:0]  dev_addr;
  logic        done_flag;
  logic        sie_clk_en;
  logic        low_power;
  logic [7:0]  d;
  int          fail_count = 0;
  int          num_checks = 0;
  logic [11:0] tt [8] = '{12'h140, 12'h147, 12'h124, 12'h062, 12'h168, 12'h14b, 12'h1eb, 12'h123};
  logic [7:0]  st [4] = '{8'h0a, 8'h14, 8'h18, 8'h26};
  logic [15:0] ra [6] = '{16'h2000, 16'h21ef, 16'h0370, 16'h037f, 16'h2200, 16'h23ff};

  usd_core dut (.ref_clk(ref_clk), .reset_n(reset_n), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
    .eng_tok(eng_tok), .eng_hs(eng_hs), .eng_done(eng_done), .eng_stall(eng_stall),
    .eng_bus_reset(eng_bus_reset), .eng_sof(eng_sof), .eng_sof_frame(eng_sof_frame),
    .eng_rd_idx(eng_rd_idx), .eng_rd_data(eng_rd_data), .dev_addr(dev_addr),
    .done_flag(done_flag), .sie_clk_en(sie_clk_en), .low_power(low_power));
  usd_host_model host (.ref_clk(ref_clk), .eng_hs(eng_hs), .eng_rd_data(eng_rd_data),
    .eng_tok(eng_tok), .eng_done(eng_done), .eng_stall(eng_stall),
    .eng_bus_reset(eng_bus_reset), .eng_sof(eng_sof), .eng_sof_frame(eng_sof_frame),
    .eng_rd_idx(eng_rd_idx));

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_wdata <= v;
    cpu_wr <= 1'b1;
    @(posedge ref_clk);
    cpu_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge ref_clk);
    cpu_rd <= 1'b0;
    #1 chk(cpu_rdata, exp);
  endtask
  task automatic wait_done(input int lim);
    int n;
    n = 0;
    while (done_flag !== 1'b1 && n < lim)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk({7'h0, done_flag}, 8'h01);
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    stop_test();
  end
  initial
  begin
    reset_n = 1'b0;
    cpu_addr = '0;
    cpu_wdata = '0;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1 chk({6'h0, sie_clk_en, low_power}, 8'h02);
    chk(dev_addr, 8'h00);
    rdchk(`USD_OFF_ADDR, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr(`USD_OFF_EP_BASE + 16'(i), 8'h1e);
      rdchk(`USD_OFF_EP_BASE + 16'(i), 8'h1e);
      wr(`USD_OFF_EP_BASE + 16'(i), 8'h00);
    end
    for (int k = 0; k < 8; k++)
    begin
      wr(`USD_OFF_EP_BASE + 16'h3, tt[k][11:4]);
      host.token(3'h3, usd_pid_t'(tt[k][3:2]), hs);
      chk({6'h0, hs}, {6'h0, tt[k][1:0]});
    end
    wr(`USD_OFF_EP_BASE + 16'h3, 8'h16);
    wr(`USD_OFF_EP_BASE + 16'h1, 8'h12);
    wr(16'h2003, 8'h80);
    wr(16'h2004, 8'h40);
    wr(16'h2007, 8'h80);
    host.done(3'h1, 1'b0, 1'b1, 7'd1, 4'h9, 10'h2c5);
    host.done(3'h2, 1'b1, 1'b0, 7'd2, 4'h1, 10'h011);
    host.done(3'h3, 1'b0, 1'b0, 7'd3, 4'h2, 10'h000);
    host.done(3'h4, 1'b1, 1'b1, 7'd4, 4'h3, 10'h3ff);
    host.done(3'h5, 1'b0, 1'b0, 7'd5, 4'h4, 10'h001);
    host.done_end();
    wait_done(8);
    host.token(3'h3, USD_PID_OUT, hs);
    chk({6'h0, hs}, {6'h0, USD_HS_NAK});
    for (int k = 0; k < 4; k++)
    begin
      rdchk(`USD_OFF_STAT, st[k]);
      wr(`USD_OFF_CTRL, 8'h00);
      #1 chk({7'h0, done_flag}, 8'h00);
      if (k < 3)
        wait_done(`USD_REARM_CYC);
    end
    repeat (`USD_REARM_CYC + 2) @(posedge ref_clk);
    #1 chk({7'h0, done_flag}, 8'h00);
    rdchk(16'h2003, 8'h26);
    rdchk(16'h2004, 8'hc5);
    rdchk(16'h2007, 8'h80);
    host.ram_rd(9'd3, d);
    chk(d, 8'h26);
    host.stall(3'h5);
    rdchk(`USD_OFF_EP_BASE + 16'h5, 8'h01);
    repeat (3) @(posedge ref_clk);
    rdchk(`USD_OFF_EP_BASE + 16'h5, 8'h01);
    wr(`USD_OFF_EP_BASE + 16'h5, 8'h00);
    rdchk(`USD_OFF_EP_BASE + 16'h5, 8'h00);
    wr(`USD_OFF_ADDR, 8'h2a);
    rdchk(`USD_OFF_ADDR, 8'h2a);
    chk(dev_addr, 8'h2a);
    host.bus_reset();
    #1 chk(dev_addr, 8'h00);
    rdchk(`USD_OFF_CTRL, 8'h04);
    wr(`USD_OFF_CTRL, 8'h00);
    rdchk(`USD_OFF_CTRL, 8'h00);
    host.sof(11'h5a3);
    rdchk(`USD_OFF_FRML, 8'ha3);
    rdchk(`USD_OFF_FRMH, 8'h05);
    wr(`USD_OFF_FRML, 8'h00);
    rdchk(`USD_OFF_FRML, 8'ha3);
    wr(`USD_OFF_CTRL, 8'h02);
    #1 chk({6'h0, sie_clk_en, low_power}, 8'h01);
    host.sof(11'h123);
    rdchk(`USD_OFF_FRML, 8'ha3);
    wr(`USD_OFF_CTRL, 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      wr(ra[k], ra[k][7:0] ^ 8'h5a);
      rdchk(ra[k], ra[k][7:0] ^ 8'h5a);
    end
    host.ram_rd(9'd496, d);
    chk(d, 8'h2a);
    host.ram_rd(9'd495, d);
    chk(d, 8'hb5);
    rdchk(16'h2400, 8'h00);
    rdchk(16'h29af, 8'h00);
    rdchk(16'h0e08, 8'h00);
    stop_test();
  end
endmodule
